// *** core/rtms_defs.svh ***
// register indices, field positions, reset values and fixed addresses
`ifndef RTMS_DEFS_SVH
`define RTMS_DEFS_SVH
`define RTMS_IDX_MASK     4'h0
`define RTMS_IDX_CFG1     4'h1
`define RTMS_IDX_CFG2     4'h2
`define RTMS_IDX_START    4'h3
`define RTMS_IDX_INTSTAT  4'h6
`define RTMS_IDX_CFG3     4'h7
`define RTMS_IDX_CFG4     4'h8
`define RTMS_IDX_CFG5     4'h9
`define RTMS_IDX_LASTCMD  4'hd
`define RTMS_IDX_STKPTR   4'he
`define RTMS_IDX_BLKSTAT  4'hf
`define RTMS_REG_RESET    16'h0000
`define RTMS_SP_RAM_ADDR  16'h0100
`define RTMS_SP_STEP      16'h0004
`define RTMS_STK_BASE_SZ  16'h0100
`define RTMS_ST_EOM       0
`define RTMS_ST_MODECODE  1
`define RTMS_ST_FMTERR    2
`define RTMS_ST_STKROLL   3
`define RTMS_ST_SACTRL    4
`define RTMS_ST_CBROLL    5
`define RTMS_ST_W         6
`define RTMS_C1_MIP       0
`define RTMS_C1_SWF_LO    7
`define RTMS_C1_SWF_HI    11
`define RTMS_C2_ENH_INT   15
`define RTMS_C2_BUSY_TBL  13
`define RTMS_C2_DBL_BUF   12
`define RTMS_C2_OVERWR    11
`define RTMS_C2_ENH_MEM   1
`define RTMS_C2_SEP_BCST  0
`define RTMS_C3_ENH_MODE  15
`define RTMS_C3_STK_HI    14
`define RTMS_C3_STK_LO    13
`define RTMS_C3_INH_ILL   4
`define RTMS_C3_INH_BUSY  3
`define RTMS_C3_FLAG_WRAP 2
`define RTMS_C3_ENH_MC    0
`define RTMS_C4_MC_OVR    13
`define RTMS_C4_LATCH_TA  3
`define RTMS_C5_TA_HI     5
`define RTMS_C5_TA_LO     1
`define RTMS_SACW_TX_INT  14
`define RTMS_SACW_RX_INT  9
`define RTMS_SACW_BC_INT  4
`endif

// *** core/rtms_pkg.sv ***
// types shared by the message status block
package rtms_pkg;
  typedef logic [15:0] rtms_word_t;
  typedef logic [3:0]  rtms_idx_t;
  typedef enum logic [0:0] {
    RTMS_IDLE    = 1'b0,
    RTMS_SERVICE = 1'b1
  } rtms_msg_state_t;
endpackage : rtms_pkg

// *** core/rtms_flag_bank.sv ***
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
module rtms_flag_bank #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clr_all,
  // flag control
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (clr_all) begin
      q <= set;
    end else begin
      q <= (q & ~clr) | set;
    end
  end
endmodule : rtms_flag_bank

// *** core/rtms_ahb_slave.sv ***
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module rtms_ahb_slave
  import rtms_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // ahb-lite
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  // register side
  output logic              reg_wr,
  output rtms_pkg::rtms_idx_t reg_idx,
  output rtms_pkg::rtms_word_t reg_wdata,
  input  rtms_pkg::rtms_word_t reg_rdata
);
  logic accept;
  logic mapped;
  logic wr_pend;
  logic rd_wait;
  logic rd_mapped;

  assign accept    = hsel & htrans[1] & hready;
  // anything but an aligned word inside the map is ignored and reads zero
  assign mapped    = (haddr[31:6] == 26'h0) & (haddr[1:0] == 2'h0) & (hsize == 3'h2);
  assign reg_wr    = wr_pend;
  assign reg_wdata = hwdata[15:0];
  assign hreadyout = ~rd_wait;
  assign hresp     = 1'b0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      rd_wait   <= 1'b0;
      rd_mapped <= 1'b0;
      reg_idx   <= 4'h0;
    end else begin
      wr_pend <= accept & hwrite & mapped;
      rd_wait <= accept & ~hwrite;
      if (accept) begin
        reg_idx   <= haddr[5:2];
        rd_mapped <= mapped;
      end
    end
  end

  // the wait cycle lets a write that just finished show in the read value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (rd_wait) begin
      hrdata <= rd_mapped ? {16'h0, reg_rdata} : 32'h0;
    end
  end
endmodule : rtms_ahb_slave

// *** core/rtms_top.sv ***
// remote terminal message service status and configuration registers
//
// Functional notes
// [RULE1] start register write 0001 soft-resets terminal
// [RULE2] configuration 3 bit 15 sets enhanced mode
// [RULE3] enhanced: message-in-progress bit tracks servicing
// [RULE4] stack pointer advances four per message start
// [RULE5] last command loaded at message start
// [RULE6] message completion sets end-of-message status bit
// [RULE7] enhanced interrupts: status sets ignoring mask
// [RULE8] otherwise mask gates status and interrupt
// [RULE9] subaddress control word end flag sets status
// [RULE10] selected mode code completion sets status
// [RULE11] format error for received-message errors
// [RULE12] stack wrap at programmed boundary flags rollover
// [RULE13] circular buffer wrap sets rollover status
// [RULE14] overwrite invalid data holds circular buffer
// [RULE15] block status error bits 12-9, 6-0
// [RULE16] configuration 1 ones clear status word flags
// [RULE17] mask 0036 enables four event interrupts
// [RULE18] configuration 3 inhibits, flag wrap, mode codes; flag wrap bit 2 is unused and stack rollover status ignores it
// [RULE19] configuration 4 override busy, latch address; override bit 13 is unused
// [RULE20] configuration 5 options and terminal address
// [RULE21] configuration 2 enhanced memory and buffering
// [RULE22] host primes stack pointer and status words
`timescale 1ns/1ps
`include "rtms_defs.svh"
module rtms_top (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // ahb-lite register bus
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  // message events from the protocol engine
  input  wire logic         msg_start,
  input  rtms_pkg::rtms_word_t msg_cmd,
  input  wire logic         msg_done,
  input  wire logic [10:0]  msg_err,
  input  wire logic         msg_is_mode_code,
  input  wire logic         msg_broadcast,
  input  rtms_pkg::rtms_word_t msg_sa_ctrl,
  input  rtms_pkg::rtms_word_t msg_mc_select,
  input  wire logic         msg_illegal,
  input  wire logic         msg_busy,
  input  wire logic         cbuf_wrap,
  input  wire logic [4:0]   status_word_set,
  input  wire logic [4:0]   strap_addr,
  // stack pointer write-back to shared ram
  output logic              sp_ram_we,
  output rtms_pkg::rtms_word_t sp_ram_addr,
  output rtms_pkg::rtms_word_t sp_ram_data,
  // results to the engine and host
  output rtms_pkg::rtms_word_t block_status,
  output logic              cbuf_advance,
  output logic              store_inhibit,
  output logic              soft_reset,
  output logic              irq,
  output logic [4:0]        status_word_flags,
  output logic [4:0]        rt_address,
  output rtms_pkg::rtms_word_t cfg2_out,
  output rtms_pkg::rtms_word_t cfg3_out,
  output rtms_pkg::rtms_word_t cfg4_out,
  output rtms_pkg::rtms_word_t cfg5_out
);
  import rtms_pkg::*;

  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  logic       reg_wr;
  rtms_idx_t  reg_idx;
  rtms_word_t reg_wdata;
  rtms_word_t reg_rdata;

  rtms_ahb_slave u_bus (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .reg_wr    (reg_wr),
    .reg_idx   (reg_idx),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  rtms_word_t      int_mask;
  rtms_word_t      cfg1;
  rtms_word_t      cfg2;
  rtms_word_t      cfg3;
  rtms_word_t      cfg4;
  rtms_word_t      cfg5;
  rtms_word_t      last_cmd;
  rtms_word_t      stack_ptr;
  rtms_msg_state_t msg_state;
  logic [`RTMS_ST_W-1:0] int_status;
  logic [`RTMS_ST_W-1:0] st_event;
  logic [`RTMS_ST_W-1:0] st_clr;
  logic            enh_mode;
  logic            enh_int;

  assign soft_reset = reg_wr & (reg_idx == `RTMS_IDX_START) & reg_wdata[0]; // [RULE1]
  assign enh_mode   = cfg3[`RTMS_C3_ENH_MODE]; // [RULE2]
  assign enh_int    = enh_mode & cfg2[`RTMS_C2_ENH_INT];

  // soft reset returns the mask and configuration registers to their power-up value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= `RTMS_REG_RESET;
      cfg1     <= `RTMS_REG_RESET;
      cfg2     <= `RTMS_REG_RESET;
      cfg3     <= `RTMS_REG_RESET;
      cfg4     <= `RTMS_REG_RESET;
      cfg5     <= `RTMS_REG_RESET;
    end else if (soft_reset) begin // [RULE1]
      int_mask <= `RTMS_REG_RESET;
      cfg1     <= `RTMS_REG_RESET;
      cfg2     <= `RTMS_REG_RESET;
      cfg3     <= `RTMS_REG_RESET;
      cfg4     <= `RTMS_REG_RESET;
      cfg5     <= `RTMS_REG_RESET;
    end else if (reg_wr) begin
      unique case (reg_idx)
        `RTMS_IDX_MASK: int_mask <= reg_wdata; // [RULE17]
        `RTMS_IDX_CFG1: cfg1     <= reg_wdata; // [RULE16]
        `RTMS_IDX_CFG2: cfg2     <= reg_wdata; // [RULE21]
        `RTMS_IDX_CFG3: cfg3     <= reg_wdata; // [RULE2] [RULE18]
        `RTMS_IDX_CFG4: cfg4     <= reg_wdata; // [RULE19]
        `RTMS_IDX_CFG5: cfg5     <= reg_wdata; // [RULE20]
        default: ;
      endcase
    end
  end

  assign cfg2_out = cfg2;
  assign cfg3_out = cfg3;
  assign cfg4_out = cfg4;
  assign cfg5_out = cfg5;

  // terminal address comes from configuration 5 only when latching is selected
  assign rt_address = cfg4[`RTMS_C4_LATCH_TA] ?
                      cfg5[`RTMS_C5_TA_HI:`RTMS_C5_TA_LO] : strap_addr; // [RULE19] [RULE20]

  // illegal or busy messages keep their data out of ram when inhibited
  assign store_inhibit = (msg_illegal & cfg3[`RTMS_C3_INH_ILL]) |
                         (msg_busy & cfg3[`RTMS_C3_INH_BUSY]); // [RULE18]

  // ----------------------------------------
  // status word flags in configuration 1
  // ----------------------------------------
  logic [4:0] swf_clr;

  assign swf_clr = (reg_wr && reg_idx == `RTMS_IDX_CFG1) ?
                   reg_wdata[`RTMS_C1_SWF_HI:`RTMS_C1_SWF_LO] : 5'h00; // [RULE16]

  rtms_flag_bank #(.W(5)) u_swf (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr_all (soft_reset),
    .set     (status_word_set),
    .clr     (swf_clr),
    .q       (status_word_flags)
  );

  // ----------------------------------------
  // message tracking
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_state <= RTMS_IDLE;
    end else if (soft_reset) begin
      msg_state <= RTMS_IDLE;
    end else begin
      unique case (msg_state)
        RTMS_IDLE:    if (msg_start) msg_state <= RTMS_SERVICE; // [RULE3]
        RTMS_SERVICE: if (msg_done) msg_state <= RTMS_IDLE;     // [RULE3]
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_cmd <= `RTMS_REG_RESET;
    end else if (soft_reset) begin
      last_cmd <= `RTMS_REG_RESET;
    end else if (msg_start) begin
      last_cmd <= msg_cmd; // [RULE5]
    end
  end

  // ----------------------------------------
  // command stack pointer
  // ----------------------------------------
  rtms_word_t stk_mask;
  rtms_word_t next_sp;
  logic       stk_wrap;

  always_comb begin
    unique case (cfg3[`RTMS_C3_STK_HI:`RTMS_C3_STK_LO])
      2'h0: stk_mask = `RTMS_STK_BASE_SZ - 16'h0001;
      2'h1: stk_mask = (`RTMS_STK_BASE_SZ << 1) - 16'h0001;
      2'h2: stk_mask = (`RTMS_STK_BASE_SZ << 2) - 16'h0001;
      2'h3: stk_mask = (`RTMS_STK_BASE_SZ << 3) - 16'h0001;
    endcase
    stk_wrap = ((stack_ptr & stk_mask) + `RTMS_SP_STEP) > stk_mask; // [RULE12]
    next_sp  = stk_wrap ? (stack_ptr & ~stk_mask) : (stack_ptr + `RTMS_SP_STEP); // [RULE4]
  end

  // the host primes the pointer through the register before the first message
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr   <= `RTMS_REG_RESET;
      sp_ram_we   <= 1'b0;
      sp_ram_data <= `RTMS_REG_RESET;
    end else if (soft_reset) begin
      stack_ptr   <= `RTMS_REG_RESET;
      sp_ram_we   <= 1'b0;
      sp_ram_data <= `RTMS_REG_RESET;
    end else begin
      sp_ram_we <= msg_start;
      if (msg_start) begin
        stack_ptr   <= next_sp; // [RULE4]
        sp_ram_data <= next_sp;
      end else if (reg_wr && reg_idx == `RTMS_IDX_STKPTR) begin
        stack_ptr <= reg_wdata; // [RULE22]
      end
    end
  end

  assign sp_ram_addr = `RTMS_SP_RAM_ADDR;

  // ----------------------------------------
  // completion results
  // ----------------------------------------
  logic sa_int_sel;
  logic mc_sel;
  logic fmt_err;

  assign fmt_err    = |msg_err; // [RULE11]
  assign sa_int_sel = msg_is_mode_code ? 1'b0 :
                      msg_broadcast ? msg_sa_ctrl[`RTMS_SACW_BC_INT] :
                      msg_cmd[10] ? msg_sa_ctrl[`RTMS_SACW_TX_INT] :
                      msg_sa_ctrl[`RTMS_SACW_RX_INT];
  assign mc_sel     = msg_is_mode_code & msg_mc_select[msg_cmd[3:0]];

  // block status error field, written once per completed message
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_status <= `RTMS_REG_RESET;
      cbuf_advance <= 1'b0;
    end else if (soft_reset) begin
      block_status <= `RTMS_REG_RESET;
      cbuf_advance <= 1'b0;
    end else begin
      // with overwrite set, an errored message leaves the buffer where it was so the retry lands on top
      cbuf_advance <= msg_done & ~(fmt_err & cfg2[`RTMS_C2_OVERWR]); // [RULE14]
      if (msg_done) begin
        block_status <= {3'h0, msg_err[10:7], 2'h0, msg_err[6:0]}; // [RULE15]
      end
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  logic [`RTMS_ST_W-1:0] st_gate;
  logic [`RTMS_ST_W-1:0] st_set;

  always_comb begin
    st_event = '0;
    st_event[`RTMS_ST_EOM]      = msg_done; // [RULE6]
    st_event[`RTMS_ST_MODECODE] = msg_done & cfg3[`RTMS_C3_ENH_MC] & mc_sel; // [RULE10]
    st_event[`RTMS_ST_FMTERR]   = msg_done & fmt_err; // [RULE11]
    st_event[`RTMS_ST_STKROLL]  = msg_start & stk_wrap; // [RULE12]
    st_event[`RTMS_ST_SACTRL]   = msg_done & cfg2[`RTMS_C2_ENH_MEM] & sa_int_sel; // [RULE9]
    st_event[`RTMS_ST_CBROLL]   = cbuf_wrap; // [RULE13]
  end

  // in enhanced interrupt mode the mask only gates the pin, not the bits
  assign st_gate = enh_int ? {`RTMS_ST_W{1'b1}} : int_mask[`RTMS_ST_W-1:0]; // [RULE7] [RULE8]
  assign st_clr  = (reg_wr && reg_idx == `RTMS_IDX_INTSTAT) ?
                   reg_wdata[`RTMS_ST_W-1:0] : '0;
  assign st_set  = st_event & st_gate;

  rtms_flag_bank #(.W(`RTMS_ST_W)) u_int (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr_all (soft_reset),
    .set     (st_set),
    .clr     (st_clr),
    .q       (int_status)
  );

  assign irq = |(int_status & int_mask[`RTMS_ST_W-1:0]); // [RULE8] [RULE17]

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always_comb begin
    reg_rdata = 16'h0000;
    unique case (reg_idx)
      `RTMS_IDX_MASK:    reg_rdata = int_mask;
      `RTMS_IDX_CFG1: begin
        reg_rdata = cfg1;
        reg_rdata[`RTMS_C1_SWF_HI:`RTMS_C1_SWF_LO] = status_word_flags;
        reg_rdata[`RTMS_C1_MIP] = enh_mode & (msg_state == RTMS_SERVICE); // [RULE3]
      end
      `RTMS_IDX_CFG2:    reg_rdata = cfg2;
      `RTMS_IDX_INTSTAT: reg_rdata = {10'h000, int_status};
      `RTMS_IDX_CFG3:    reg_rdata = cfg3;
      `RTMS_IDX_CFG4:    reg_rdata = cfg4;
      `RTMS_IDX_CFG5:    reg_rdata = cfg5;
      `RTMS_IDX_LASTCMD: reg_rdata = last_cmd;
      `RTMS_IDX_STKPTR:  reg_rdata = stack_ptr;
      `RTMS_IDX_BLKSTAT: reg_rdata = block_status;
      default:           reg_rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_soft_reset_clr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
    soft_reset |=> (cfg3 == 16'h0000 && int_status == $past(st_set) && msg_state == RTMS_IDLE))
    else $error("soft reset did not clear state");

  a_mip_service: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
    (msg_start && !soft_reset && msg_state == RTMS_IDLE) |=>
      (msg_state == RTMS_SERVICE) until_with (msg_done || soft_reset))
    else $error("message in progress dropped early");

  a_sp_advance: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
    (msg_start && !soft_reset && !stk_wrap) |=> stack_ptr == $past(stack_ptr) + 16'h0004)
    else $error("stack pointer did not advance by four");

  a_sp_ram_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
    (msg_start && !soft_reset) |=> (sp_ram_we && sp_ram_data == stack_ptr))
    else $error("stack pointer not written back");

  a_last_cmd_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
    (msg_start && !soft_reset) |=> last_cmd == $past(msg_cmd))
    else $error("last command not loaded");

  a_eom_enh_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
    (msg_done && enh_int && !soft_reset) |=> int_status[`RTMS_ST_EOM])
    else $error("end of message bit not set");

  a_mask_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
    (!enh_int && !int_mask[`RTMS_ST_FMTERR] && !int_status[`RTMS_ST_FMTERR])
      |=> !int_status[`RTMS_ST_FMTERR])
    else $error("masked format error bit set");

  a_fmt_err_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
    (msg_done && |msg_err && enh_int && !soft_reset) ##1 1'b1 |->
      int_status[`RTMS_ST_FMTERR] && {7'h00, block_status[12:9]} == ($past(msg_err) >> 7))
    else $error("format error not reported");

  a_stk_roll: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
    (msg_start && stk_wrap && enh_int && !soft_reset) |=>
      (int_status[`RTMS_ST_STKROLL] && (stack_ptr & stk_mask) == 16'h0000))
    else $error("stack rollover not flagged");

  a_hold_on_error: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE14]
    (msg_done && fmt_err && cfg2[`RTMS_C2_OVERWR]) |=> !cbuf_advance)
    else $error("buffer advanced past invalid data");

  a_irq_on_mask: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
    (msg_done && int_mask[`RTMS_ST_EOM] && !soft_reset && !reg_wr) |=> irq)
    else $error("enabled end of message raised no interrupt");
endmodule : rtms_top

// *** dv/rtms_msg_model.sv ***
// bus controller side model: frames command and completion events
`timescale 1ns/1ps
module rtms_msg_model (
  // clock
  input  wire logic  ref_clk,
  // message events
  output logic        msg_start,
  output logic [15:0] msg_cmd,
  output logic        msg_done,
  output logic [10:0] msg_err,
  output logic        msg_is_mode_code,
  output logic        msg_broadcast,
  output logic [15:0] msg_sa_ctrl,
  output logic [15:0] msg_mc_select,
  output logic        cbuf_wrap
);
  initial begin
    {msg_start, msg_done, msg_is_mode_code, msg_broadcast, cbuf_wrap} = 5'h0;
    {msg_cmd, msg_sa_ctrl, msg_mc_select} = 48'h0;
    msg_err = 11'h0;
  end
  // ----------------------------------------
  // one message: start, gap cycles, done
  // ----------------------------------------
  task run_msg(input logic [15:0] cmd, input logic [10:0] err, input logic [15:0] sa,
               input logic [15:0] mc, input logic mcf, input logic bc, input logic wr,
               input int gap);
    msg_start <= 1'b1;
    msg_cmd   <= cmd;
    @(posedge ref_clk);
    msg_start <= 1'b0;
    repeat (gap) @(posedge ref_clk);
    msg_done         <= 1'b1;
    msg_err          <= err;
    msg_sa_ctrl      <= sa;
    msg_mc_select    <= mc;
    msg_is_mode_code <= mcf;
    msg_broadcast    <= bc;
    cbuf_wrap        <= wr;
    @(posedge ref_clk);
    msg_done  <= 1'b0;
    cbuf_wrap <= 1'b0;
    // qualifiers mean nothing outside done, so they must not linger
    msg_err       <= ~err;
    msg_sa_ctrl   <= ~sa;
    msg_mc_select <= ~mc;
    msg_cmd       <= ~cmd;
  endtask : run_msg
endmodule : rtms_msg_model

// *** dv/test_rtms_top.sv ***
// self-checking bench for the message status block
`timescale 1ns/1ps
`include "rtms_defs.svh"
module test_rtms_top;
  import rtms_pkg::*;
  logic        ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, msg_start, msg_done, msg_is_mode_code, msg_broadcast;
  logic        msg_illegal = 0, msg_busy = 0, cbuf_wrap, sp_ram_we, cbuf_advance;
  logic        store_inhibit, soft_reset, irq;
  logic [10:0] msg_err;
  logic [4:0]  status_word_set = 0, strap_addr = 0, status_word_flags, rt_address;
  rtms_word_t  msg_cmd, msg_sa_ctrl, msg_mc_select, sp_ram_addr, sp_ram_data, block_status;
  rtms_word_t  cfg2_out, cfg3_out, cfg4_out, cfg5_out, rd;
  int          n_fail = 0, compares = 0, cyc = 0, seed = 98330;
  localparam rtms_idx_t  IX[7] = '{`RTMS_IDX_START, `RTMS_IDX_CFG3, `RTMS_IDX_MASK,
    `RTMS_IDX_CFG2, `RTMS_IDX_CFG3, `RTMS_IDX_CFG4, `RTMS_IDX_CFG5};
  localparam rtms_word_t IV[7] = '{16'h0001, 16'h8000, 16'h0036, 16'hb803, 16'h801d,
    16'h2008, 16'h890e};

  always #10 ref_clk = ~ref_clk;

  rtms_top dut_u (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .msg_start, .msg_cmd, .msg_done,
    .msg_err, .msg_is_mode_code, .msg_broadcast, .msg_sa_ctrl, .msg_mc_select, .msg_illegal,
    .msg_busy, .cbuf_wrap, .status_word_set, .strap_addr, .sp_ram_we, .sp_ram_addr,
    .sp_ram_data, .block_status, .cbuf_advance, .store_inhibit, .soft_reset, .irq,
    .status_word_flags, .rt_address, .cfg2_out, .cfg3_out, .cfg4_out, .cfg5_out);
  rtms_msg_model model_u (.ref_clk, .msg_start, .msg_cmd, .msg_done, .msg_err,
    .msg_is_mode_code, .msg_broadcast, .msg_sa_ctrl, .msg_mc_select, .cbuf_wrap);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task xfer(input logic w, input rtms_idx_t i, input rtms_word_t d);
    hsel   <= 1'b1;
    haddr  <= {26'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {16'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata[15:0];
  endtask : xfer
  task rchk(input string nm, input rtms_idx_t i, input rtms_word_t e);
    xfer(1'b0, i, 16'h0);
    chk(nm, e, rd);
  endtask : rchk
  function automatic rtms_word_t exp_blk(input logic [10:0] e);
    return {3'h0, e[10:7], 2'h0, e[6:0]};
  endfunction : exp_blk
  // stack of 256 words: wrap back to the block base
  function automatic rtms_word_t exp_sp(input rtms_word_t p);
    return ((p & 16'h00ff) + 16'h4 > 16'h00ff) ? (p & 16'hff00) : p + 16'h4;
  endfunction : exp_sp
  task report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin : main
    logic [15:0] cmd, sa, mc, sp;
    logic [10:0] err;
    logic        mcf, bc, wr, roll, sh;
    rtms_word_t  es;
    strap_addr <= $random(seed);
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int k = 0; k < 16; k++) rchk("reset value", k[3:0], 16'h0);
    xfer(1'b1, 4'h4, 16'hffff);
    rchk("unmapped", 4'h4, 16'h0);
    chk("hresp", 0, hresp);
    for (int k = 0; k < 7; k++) xfer(1'b1, IX[k], IV[k]);
    rchk("mask", `RTMS_IDX_MASK, 16'h0036);
    chk("cfg2", 16'hb803, cfg2_out);
    chk("cfg3", 16'h801d, cfg3_out);
    chk("cfg4", 16'h2008, cfg4_out);
    chk("cfg5", 16'h890e, cfg5_out);
    chk("rt address", 7, rt_address);
    msg_illegal <= 1'b1;
    @(posedge ref_clk) #1;
    chk("inhibit illegal", 1, store_inhibit);
    msg_illegal <= 1'b0;
    msg_busy    <= 1'b1;
    @(posedge ref_clk) #1;
    chk("inhibit busy", 1, store_inhibit);
    msg_busy <= 1'b0;
    sp = 16'h00f0;
    xfer(1'b1, `RTMS_IDX_STKPTR, sp);
    // five messages walk the pointer across the 256-word boundary
    for (int m = 0; m < 5; m++) begin
      cmd = $random(seed);
      err = (m == 0) ? 11'h681 : (($random(seed) & 1) ? $random(seed) : 11'h0);
      mc  = $random(seed);
      {mcf, bc, wr} = $random(seed);
      sa  = mcf ? 16'h0 : $random(seed);
      fork
        model_u.run_msg(cmd, err, sa, mc, mcf, bc, wr, 8);
        begin
          @(posedge ref_clk) #1;
          chk("ram write", 1, sp_ram_we);
        end
        begin
          rchk("in progress", `RTMS_IDX_CFG1, 16'h0001);
          rchk("last command", `RTMS_IDX_LASTCMD, cmd);
        end
      join
      #1;
      roll = (sp & 16'h00ff) + 16'h4 > 16'h00ff;
      sp = exp_sp(sp);
      sh = bc ? sa[4] : (cmd[10] ? sa[14] : sa[9]);
      es = {10'h0, wr, sh, roll, |err, mcf & mc[cmd[3:0]], 1'b1};
      chk("ram pointer", sp, sp_ram_data);
      chk("ram address", 16'h0100, sp_ram_addr);
      chk("buffer advance", err == 0, cbuf_advance);
      chk("block status", exp_blk(err), block_status);
      chk("irq", (es & 16'h36) != 0, irq);
      rchk("int status", `RTMS_IDX_INTSTAT, es);
      rchk("stack pointer", `RTMS_IDX_STKPTR, sp);
      xfer(1'b1, `RTMS_IDX_INTSTAT, 16'h003f);
    end
    // larger stacks wrap only at their own boundary
    for (int k = 1; k < 4; k++) begin
      xfer(1'b1, `RTMS_IDX_CFG3, {1'b1, k[1:0], 13'h001d});
      xfer(1'b1, `RTMS_IDX_STKPTR, (16'h0100 << k) - 16'h0004);
      model_u.run_msg(16'h0, 11'h0, 16'h0, 16'h0, 1'b0, 1'b0, 1'b0, 1);
      #1;
      rchk("wide stack", `RTMS_IDX_STKPTR, 16'h0);
      xfer(1'b0, `RTMS_IDX_INTSTAT, 16'h0);
      chk("wide roll", 1, rd[3]);
      xfer(1'b1, `RTMS_IDX_INTSTAT, 16'h003f);
    end
    xfer(1'b1, `RTMS_IDX_CFG2, 16'h0);
    xfer(1'b1, `RTMS_IDX_MASK, 16'h0001);
    model_u.run_msg(16'h0403, 11'h7ff, 16'hffff, 16'hffff, 1'b1, 1'b0, 1'b1, 0);
    #1;
    rchk("masked status", `RTMS_IDX_INTSTAT, 16'h0001);
    chk("masked irq", 1, irq);
    rchk("idle", `RTMS_IDX_CFG1, 16'h0);
    xfer(1'b1, `RTMS_IDX_INTSTAT, 16'h003f);
    #1;
    chk("irq cleared", 0, irq);
    status_word_set <= 5'h1f;
    @(posedge ref_clk);
    status_word_set <= 5'h0;
    rchk("word flags", `RTMS_IDX_CFG1, 16'h0f80);
    xfer(1'b1, `RTMS_IDX_CFG1, 16'h8f80);
    rchk("flags cleared", `RTMS_IDX_CFG1, 16'h8000);
    chk("flag outputs", 0, status_word_flags);
    fork
      xfer(1'b1, `RTMS_IDX_START, 16'h0001);
      begin
        @(posedge ref_clk) #1;
        chk("soft reset", 1, soft_reset);
      end
    join
    @(posedge ref_clk) #1;
    chk("cfg3 after reset", 0, cfg3_out);
    chk("strap address", strap_addr, rt_address);
    rchk("mask after reset", `RTMS_IDX_MASK, 16'h0);
    report_and_stop();
  end
endmodule : test_rtms_top
